// file: core/ibseq_pkg.sv
// Purpose: shared constants and types for the two-wire master sequencer
// Assumes: 250 MHz core clock, word-indexed register port
// Notes: register offsets are word indexes on the plain register port
`default_nettype none
package ibseq_pkg;
  // ************************************************
  // register map
  // ************************************************
  localparam logic [3:0] ADDR_CONTROL = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h1;
  localparam logic [3:0] ADDR_TRANSMIT = 4'h2;
  localparam logic [3:0] ADDR_RECEIVE = 4'h3;
  localparam logic [3:0] ADDR_IRQ_STATUS = 4'h4;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'h5;
  localparam logic [3:0] ADDR_DIVIDER = 4'h6;

  // ************************************************
  // control bits
  // ************************************************
  localparam int CTL_START = 0;
  localparam int CTL_RESTART = 1;
  localparam int CTL_STOP = 2;
  localparam int CTL_RECEIVE = 3;
  localparam int CTL_ACK_SEQ = 4;
  localparam int CTL_ACK_VALUE = 5;
  localparam int CTL_ENABLE = 15;

  // ************************************************
  // status bits
  // ************************************************
  localparam int STA_TX_FULL = 0;
  localparam int STA_RX_FULL = 1;
  localparam int STA_RX_OVERFLOW = 6;
  localparam int STA_WRITE_COLL = 7;
  localparam int STA_BUS_COLL = 10;
  localparam int STA_TX_ACTIVE = 14;
  localparam int STA_ACK_RECEIVED = 15;

  // interrupt status bits
  localparam int IRQ_DONE = 0;
  localparam int IRQ_BUS_COLL = 1;
  localparam int IRQ_WRITE_COLL = 2;
  localparam int IRQ_WIDTH = 3;

  localparam logic [15:0] CONTROL_RESET = 16'h0000;
  localparam logic [15:0] DIVIDER_RESET = 16'h0009;
  localparam int BIT_COUNT = 8;

  typedef enum {
    ST_IDLE, ST_START, ST_RESTART, ST_STOP, ST_TX, ST_RX, ST_ACK
  } ibseq_state_type;

  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic write;
    logic read;
  } ibseq_req_type;
endpackage
`default_nettype wire

// file: core/ibseq_master.sv
// Purpose: master-side bus sequencer of a two-wire serial controller
// Assumes: open-drain lines resolved outside; one request in flight at a time
// Notes: each sequence step is four quarter-bit ticks of the divider
// How it works
// - ack slot drives stored ack value
// - ack request starts ack sequence on lines
// - hardware clears ack request at sequence end
// - receive request clocks in one byte
// - stop request makes stop, then clears
// - restart request makes repeated start, clears
// - start request makes start, then clears
// - tx active flag covers byte plus ack
// - bus collision flag sticky until cleared
// - transmit write while busy sets collision
`default_nettype none
module ibseq_master (
  input wire logic clock_in,
  input wire logic reset_n_in,
  input wire logic [3:0] reg_addr_in,
  input wire logic [15:0] reg_wdata_in,
  input wire logic reg_write_in,
  input wire logic reg_read_in,
  output logic [15:0] reg_rdata_out,
  input wire logic serial_data_line_in,
  output logic serial_data_line_out,
  output logic serial_data_line_oe_out,
  input wire logic serial_clock_line_in,
  output logic serial_clock_line_out,
  output logic serial_clock_line_oe_out,
  output logic irq_out
);
  // ************************************************
  // pin synchronisers
  // ************************************************
  logic [1:0] sda_sync_reg;
  logic [1:0] scl_sync_reg;
  logic sda_reg;
  logic scl_reg;

  always_ff @(posedge clock_in)
  begin
    if (!reset_n_in)
    begin
      sda_sync_reg <= 2'h3;
      scl_sync_reg <= 2'h3;
    end
    else
    begin
      sda_sync_reg <= {sda_sync_reg[0], serial_data_line_in};
      scl_sync_reg <= {scl_sync_reg[0], serial_clock_line_in};
    end
  end
  assign sda_reg = sda_sync_reg[1];
  assign scl_reg = scl_sync_reg[1];

  // ************************************************
  // register port
  // ************************************************
  ibseq_pkg::ibseq_req_type req;
  assign req = '{addr: reg_addr_in, wdata: reg_wdata_in, write: reg_write_in,
                 read: reg_read_in};

  function automatic logic hit(input ibseq_pkg::ibseq_req_type r, input logic [3:0] a);
    hit = r.write && (r.addr == a);
  endfunction

  ibseq_pkg::ibseq_state_type state_reg;
  logic [15:0] control_reg;
  logic [15:0] divider_reg;
  logic [7:0] transmit_reg;
  logic [7:0] shift_reg;
  logic [7:0] receive_reg;
  logic [3:0] bit_reg;
  logic [1:0] phase_reg;
  logic [15:0] div_count_reg;
  logic tick;
  logic busy;
  logic step_end;
  logic seq_done;
  logic tx_full_reg;
  logic rx_full_reg;
  logic rx_overflow_reg;
  logic write_coll_reg;
  logic bus_coll_reg;
  logic tx_active_reg;
  logic ack_received_reg;
  logic sda_drive_reg;
  logic scl_drive_reg;
  logic [ibseq_pkg::IRQ_WIDTH-1:0] irq_status_reg;
  logic [ibseq_pkg::IRQ_WIDTH-1:0] irq_mask_reg;
  logic collision;
  logic write_coll_event;

  assign busy = (state_reg != ibseq_pkg::ST_IDLE);
  assign step_end = tick && (phase_reg == 2'h3);

  // ************************************************
  // quarter-bit divider
  // ************************************************
  always_ff @(posedge clock_in)
  begin
    if (!reset_n_in)
    begin
      div_count_reg <= 16'h0000;
      tick <= 1'b0;
    end
    else if (!busy || div_count_reg == divider_reg)
    begin
      div_count_reg <= 16'h0000;
      tick <= busy;
    end
    else
    begin
      div_count_reg <= div_count_reg + 16'h0001;
      tick <= 1'b0;
    end
  end

  // ************************************************
  // control register and request clearing
  // ************************************************
  always_ff @(posedge clock_in)
  begin
    if (!reset_n_in)
      control_reg <= ibseq_pkg::CONTROL_RESET;
    else if (hit(req, ibseq_pkg::ADDR_CONTROL))
      control_reg <= req.wdata;
    else if (seq_done || collision)
      control_reg[ibseq_pkg::CTL_ACK_SEQ:ibseq_pkg::CTL_START] <= 5'h00;
  end

  always_ff @(posedge clock_in)
  begin
    if (!reset_n_in)
      divider_reg <= ibseq_pkg::DIVIDER_RESET;
    else if (hit(req, ibseq_pkg::ADDR_DIVIDER))
      divider_reg <= req.wdata;
  end

  // ************************************************
  // sequencer
  // ************************************************
  // seq_done pulses in the cycle the last step of any sequence but a transmitted byte ends
  assign seq_done = step_end && (state_reg != ibseq_pkg::ST_TX) &&
                    (state_reg != ibseq_pkg::ST_RX || bit_reg == 4'h7);
  // driving released data but reading low means another master won;
  // the slave owns the data line in receive and in the transmit ack slot
  assign collision = busy && tick && phase_reg == 2'h2 && sda_drive_reg &&
                     !sda_reg && state_reg != ibseq_pkg::ST_RX &&
                     !(state_reg == ibseq_pkg::ST_TX && bit_reg == 4'h8);
  assign write_coll_event = hit(req, ibseq_pkg::ADDR_TRANSMIT) && busy;

  always_ff @(posedge clock_in)
  begin
    if (!reset_n_in)
    begin
      state_reg <= ibseq_pkg::ST_IDLE;
      phase_reg <= 2'h0;
      bit_reg <= 4'h0;
      shift_reg <= 8'h00;
    end
    else if (collision)
      state_reg <= ibseq_pkg::ST_IDLE;
    else
    begin
      case (state_reg)
        ibseq_pkg::ST_IDLE:
        begin
          phase_reg <= 2'h0;
          bit_reg <= 4'h0;
          if (control_reg[ibseq_pkg::CTL_ENABLE])
          begin
            // one request at a time; lowest bit served first
            if (control_reg[ibseq_pkg::CTL_START])
              state_reg <= ibseq_pkg::ST_START;
            else if (control_reg[ibseq_pkg::CTL_RESTART])
              state_reg <= ibseq_pkg::ST_RESTART;
            else if (control_reg[ibseq_pkg::CTL_STOP])
              state_reg <= ibseq_pkg::ST_STOP;
            else if (control_reg[ibseq_pkg::CTL_RECEIVE])
              state_reg <= ibseq_pkg::ST_RX;
            else if (control_reg[ibseq_pkg::CTL_ACK_SEQ])
              state_reg <= ibseq_pkg::ST_ACK;
            else if (tx_full_reg)
            begin
              state_reg <= ibseq_pkg::ST_TX;
              shift_reg <= transmit_reg;
            end
          end
        end
        ibseq_pkg::ST_TX:
          if (tick)
          begin
            phase_reg <= phase_reg + 2'h1;
            if (phase_reg == 2'h3 && bit_reg != 4'h8)
              shift_reg <= {shift_reg[6:0], 1'b0};
            if (phase_reg == 2'h3)
            begin
              bit_reg <= bit_reg + 4'h1;
              if (bit_reg == 4'h8)
                state_reg <= ibseq_pkg::ST_IDLE;
            end
          end
        ibseq_pkg::ST_RX:
          if (tick)
          begin
            phase_reg <= phase_reg + 2'h1;
            if (phase_reg == 2'h2)
              shift_reg <= {shift_reg[6:0], sda_reg};
            if (phase_reg == 2'h3)
            begin
              bit_reg <= bit_reg + 4'h1;
              if (bit_reg == 4'h7)
                state_reg <= ibseq_pkg::ST_IDLE;
            end
          end
        default:
          if (tick)
          begin
            phase_reg <= phase_reg + 2'h1;
            if (phase_reg == 2'h3)
              state_reg <= ibseq_pkg::ST_IDLE;
          end
      endcase
    end
  end

  // ************************************************
  // line drive per phase
  // ************************************************
  always_ff @(posedge clock_in)
  begin
    if (!reset_n_in)
    begin
      sda_drive_reg <= 1'b1;
      scl_drive_reg <= 1'b1;
    end
    else if (!busy || collision)
    begin
      sda_drive_reg <= 1'b1;
      scl_drive_reg <= collision ? 1'b1 : scl_drive_reg;
    end
    else if (tick)
    begin
      case (state_reg)
        ibseq_pkg::ST_START:
        begin
          sda_drive_reg <= (phase_reg < 2'h1);
          scl_drive_reg <= (phase_reg < 2'h3);
        end
        ibseq_pkg::ST_RESTART:
        begin
          sda_drive_reg <= (phase_reg < 2'h2);
          scl_drive_reg <= (phase_reg != 2'h0) && (phase_reg != 2'h3);
        end
        ibseq_pkg::ST_STOP:
        begin
          sda_drive_reg <= (phase_reg >= 2'h2);
          scl_drive_reg <= (phase_reg != 2'h0);
        end
        ibseq_pkg::ST_ACK:
        begin
          sda_drive_reg <= control_reg[ibseq_pkg::CTL_ACK_VALUE];
          scl_drive_reg <= (phase_reg == 2'h1) || (phase_reg == 2'h2);
        end
        ibseq_pkg::ST_RX:
        begin
          sda_drive_reg <= 1'b1;
          scl_drive_reg <= (phase_reg == 2'h1) || (phase_reg == 2'h2);
        end
        ibseq_pkg::ST_TX:
        begin
          sda_drive_reg <= (bit_reg == 4'h8) ? 1'b1 : shift_reg[7];
          scl_drive_reg <= (phase_reg == 2'h1) || (phase_reg == 2'h2);
        end
        default:
        begin
          sda_drive_reg <= 1'b1;
          scl_drive_reg <= 1'b1;
        end
      endcase
    end
  end

  // open drain: only a low is ever driven
  always_ff @(posedge clock_in)
  begin
    if (!reset_n_in)
    begin
      serial_data_line_out <= 1'b0;
      serial_data_line_oe_out <= 1'b0;
      serial_clock_line_out <= 1'b0;
      serial_clock_line_oe_out <= 1'b0;
    end
    else
    begin
      serial_data_line_out <= 1'b0;
      serial_data_line_oe_out <= !sda_drive_reg;
      serial_clock_line_out <= 1'b0;
      serial_clock_line_oe_out <= !scl_drive_reg;
    end
  end

  // ************************************************
  // data and status flags
  // ************************************************
  always_ff @(posedge clock_in)
  begin
    if (!reset_n_in)
    begin
      transmit_reg <= 8'h00;
      tx_full_reg <= 1'b0;
      tx_active_reg <= 1'b0;
      ack_received_reg <= 1'b0;
    end
    else
    begin
      if (hit(req, ibseq_pkg::ADDR_TRANSMIT) && !busy)
      begin
        transmit_reg <= req.wdata[7:0];
        tx_full_reg <= 1'b1;
      end
      else if (state_reg == ibseq_pkg::ST_IDLE && tx_full_reg &&
               control_reg[ibseq_pkg::CTL_ENABLE] && control_reg[4:0] == 5'h00)
      begin
        tx_full_reg <= 1'b0;
        tx_active_reg <= 1'b1;
      end
      if (state_reg == ibseq_pkg::ST_TX && step_end && bit_reg == 4'h8)
      begin
        tx_active_reg <= 1'b0;
        ack_received_reg <= sda_reg;
      end
      else if (collision)
        tx_active_reg <= 1'b0;
    end
  end

  always_ff @(posedge clock_in)
  begin
    if (!reset_n_in)
    begin
      receive_reg <= 8'h00;
      rx_full_reg <= 1'b0;
      rx_overflow_reg <= 1'b0;
    end
    else
    begin
      if (state_reg == ibseq_pkg::ST_RX && step_end && bit_reg == 4'h7)
      begin
        receive_reg <= shift_reg;
        rx_full_reg <= 1'b1;
        if (rx_full_reg)
          rx_overflow_reg <= 1'b1;
      end
      else if (req.read && req.addr == ibseq_pkg::ADDR_RECEIVE)
        rx_full_reg <= 1'b0;
      if (hit(req, ibseq_pkg::ADDR_STATUS) && !req.wdata[ibseq_pkg::STA_RX_OVERFLOW] &&
          !(state_reg == ibseq_pkg::ST_RX && step_end && bit_reg == 4'h7 && rx_full_reg))
        rx_overflow_reg <= 1'b0;
    end
  end

  // software clears a flag by writing zero to it; a new event wins
  always_ff @(posedge clock_in)
  begin
    if (!reset_n_in)
    begin
      bus_coll_reg <= 1'b0;
      write_coll_reg <= 1'b0;
    end
    else
    begin
      if (collision)
        bus_coll_reg <= 1'b1;
      else if (hit(req, ibseq_pkg::ADDR_STATUS) && !req.wdata[ibseq_pkg::STA_BUS_COLL])
        bus_coll_reg <= 1'b0;
      if (write_coll_event)
        write_coll_reg <= 1'b1;
      else if (hit(req, ibseq_pkg::ADDR_STATUS) && !req.wdata[ibseq_pkg::STA_WRITE_COLL])
        write_coll_reg <= 1'b0;
    end
  end

  // ************************************************
  // interrupts
  // ************************************************
  logic [ibseq_pkg::IRQ_WIDTH-1:0] irq_events;
  assign irq_events = {write_coll_event, collision, seq_done};

  always_ff @(posedge clock_in)
  begin
    if (!reset_n_in)
    begin
      irq_status_reg <= '0;
      irq_mask_reg <= '0;
      irq_out <= 1'b0;
    end
    else
    begin
      if (hit(req, ibseq_pkg::ADDR_IRQ_STATUS))
        irq_status_reg <= (irq_status_reg & ~req.wdata[ibseq_pkg::IRQ_WIDTH-1:0]) |
                          irq_events;
      else
        irq_status_reg <= irq_status_reg | irq_events;
      if (hit(req, ibseq_pkg::ADDR_IRQ_MASK))
        irq_mask_reg <= req.wdata[ibseq_pkg::IRQ_WIDTH-1:0];
      irq_out <= |(irq_status_reg & irq_mask_reg);
    end
  end

  // ************************************************
  // read data
  // ************************************************
  logic [15:0] status_word;
  always_comb
  begin
    status_word = 16'h0000;
    status_word[ibseq_pkg::STA_ACK_RECEIVED] = ack_received_reg;
    status_word[ibseq_pkg::STA_TX_ACTIVE] = tx_active_reg;
    status_word[ibseq_pkg::STA_BUS_COLL] = bus_coll_reg;
    status_word[ibseq_pkg::STA_WRITE_COLL] = write_coll_reg;
    status_word[ibseq_pkg::STA_RX_OVERFLOW] = rx_overflow_reg;
    status_word[ibseq_pkg::STA_RX_FULL] = rx_full_reg;
    status_word[ibseq_pkg::STA_TX_FULL] = tx_full_reg;
  end

  always_ff @(posedge clock_in)
  begin
    if (!reset_n_in)
      reg_rdata_out <= 16'h0000;
    else if (req.read)
    begin
      case (req.addr)
        ibseq_pkg::ADDR_CONTROL: reg_rdata_out <= control_reg;
        ibseq_pkg::ADDR_STATUS: reg_rdata_out <= status_word;
        ibseq_pkg::ADDR_TRANSMIT: reg_rdata_out <= {8'h00, transmit_reg};
        ibseq_pkg::ADDR_RECEIVE: reg_rdata_out <= {8'h00, receive_reg};
        ibseq_pkg::ADDR_IRQ_STATUS: reg_rdata_out <= {13'h0000, irq_status_reg};
        ibseq_pkg::ADDR_IRQ_MASK: reg_rdata_out <= {13'h0000, irq_mask_reg};
        ibseq_pkg::ADDR_DIVIDER: reg_rdata_out <= divider_reg;
        default: reg_rdata_out <= 16'h0000;
      endcase
    end
    else
      reg_rdata_out <= 16'h0000;
  end

  // ************************************************
  // checks
  // ************************************************
  sequence start_begin_s;
    state_reg == ibseq_pkg::ST_IDLE && control_reg[ibseq_pkg::CTL_ENABLE] &&
    control_reg[ibseq_pkg::CTL_START];
  endsequence

  start_enters_a: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    start_begin_s |=> state_reg == ibseq_pkg::ST_START)
    else $error("start request not served");

  done_clears_a: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    seq_done && !hit(req, ibseq_pkg::ADDR_CONTROL) |=> control_reg[4:0] == 5'h00)
    else $error("request bits not cleared at sequence end");

  ack_value_a: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    state_reg == ibseq_pkg::ST_ACK && tick |=>
    sda_drive_reg == $past(control_reg[ibseq_pkg::CTL_ACK_VALUE]))
    else $error("ack slot does not carry ack value");

  bus_coll_a: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    collision |=> bus_coll_reg && state_reg == ibseq_pkg::ST_IDLE)
    else $error("bus collision not flagged");

  write_coll_a: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    write_coll_event |=> write_coll_reg && $stable(transmit_reg))
    else $error("busy transmit write not refused");

  tx_active_a: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    state_reg == ibseq_pkg::ST_TX |-> tx_active_reg)
    else $error("tx active low during transmit");

  rx_byte_a: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    state_reg == ibseq_pkg::ST_RX && step_end && bit_reg == 4'h7 && !collision
    |=> rx_full_reg && state_reg == ibseq_pkg::ST_IDLE)
    else $error("receive did not end after eight bits");

  stop_line_a: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    state_reg == ibseq_pkg::ST_STOP && step_end && !collision |=> sda_drive_reg && scl_drive_reg)
    else $error("stop did not release both lines");
endmodule
`default_nettype wire

// file: dv/ibseq_slave_model.sv
// Purpose: behavioural two-wire slave facing the master sequencer
// Assumes: both lines pulled up; the bench resolves every party's pull-down
// Notes: jam_in holds the data line low on command, only to provoke a collision
`default_nettype none
module ibseq_slave_model (
  input wire logic sda_in,
  input wire logic scl_in,
  input wire logic [7:0] rd_byte_in,
  input wire logic jam_in,
  output logic sda_oe_out,
  output logic ack_seen_out,
  output var int start_cnt_out,
  output var int stop_cnt_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ************************************************
  // bit and byte tracking
  // ************************************************
  logic [3:0] cnt;
  logic [7:0] shift;
  logic first, read_mode, talking, drv;
  int nbyte;
  initial
  begin
    {cnt, shift, first, read_mode, talking, drv} = '0;
    ack_seen_out = 1'b1;
    start_cnt_out = 0;
    stop_cnt_out = 0;
    nbyte = 0;
  end
  // released line floats back to the pull-up level
  assign sda_oe_out = drv | jam_in;
  always @(negedge sda_in)
  begin
    if (scl_in === 1'b1 && sda_in === 1'b0)
    begin
      start_cnt_out++;
      cnt = 4'h0;
      nbyte = 0;
      {first, read_mode, talking, drv} = 4'b1000;
    end
  end
  // a stop counts only after a start, so the power-up rise of both lines is ignored
  always @(posedge sda_in)
  begin
    if (scl_in === 1'b1 && start_cnt_out > stop_cnt_out)
    begin
      stop_cnt_out++;
      {read_mode, drv} = 2'b00;
    end
  end
  always @(posedge scl_in)
  begin
    if (cnt != 4'h8)
      shift = {shift[6:0], sda_in};
    else if (read_mode && nbyte > 0)
    begin
      ack_seen_out = sda_in;
      // a refused byte ends the reply, so the master can stop
      talking = !sda_in;
    end
  end
  always @(negedge scl_in)
  begin
    if (first)
      first = 1'b0;
    else if (cnt == 4'h8)
    begin
      cnt = 4'h0;
      nbyte++;
    end
    else
      cnt++;
    if (cnt == 4'h8 && nbyte == 0)
      {read_mode, talking} = {2{shift[0]}};
    if (cnt == 4'h8)
      drv = nbyte == 0 || !read_mode;
    else
      drv = read_mode && talking && !rd_byte_in[3'h7 - cnt[2:0]];
  end
endmodule
`default_nettype wire

// file: dv/tb_i2c_master_bus_sequencer.sv
// Purpose: self-checking bench for the two-wire master sequencer
// Assumes: divider set to 7, so a bit lasts 128 ns, near the 125 ns link period
// Notes: reads queue their expectation; a watcher compares them one cycle later
`default_nettype none
module tb_i2c_master_bus_sequencer;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {
    logic [3:0] addr;
    logic [15:0] exp;
    logic [15:0] mask;
  } ibseq_note_type;
  localparam int QTR = 8;
  logic clock_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic jam = 1'b0;
  logic rd_d = 1'b0;
  logic [7:0] rx_byte = 8'h00;
  logic [6:0] adr = 7'h00;
  ibseq_pkg::ibseq_req_type req = '0;
  logic [15:0] reg_rdata_out;
  logic d_out, d_oe, c_out, c_oe, slv_oe, irq_out, ack_seen, dline, cline;
  int start_cnt, stop_cnt;
  int err_total = 0;
  int n_compared = 0;
  int cyc = 0;
  int seed = 32'hc34b;
  ibseq_note_type notes[$];
  ibseq_note_type note;
  assign dline = (d_oe ? d_out : 1'b1) & !slv_oe;
  assign cline = c_oe ? c_out : 1'b1;
  always #2 clock_in = ~clock_in;
  ibseq_master dut (
    .clock_in(clock_in),
    .reset_n_in(reset_n_in),
    .reg_addr_in(req.addr),
    .reg_wdata_in(req.wdata),
    .reg_write_in(req.write),
    .reg_read_in(req.read),
    .reg_rdata_out(reg_rdata_out),
    .serial_data_line_in(dline),
    .serial_data_line_out(d_out),
    .serial_data_line_oe_out(d_oe),
    .serial_clock_line_in(cline),
    .serial_clock_line_out(c_out),
    .serial_clock_line_oe_out(c_oe),
    .irq_out(irq_out)
  );
  ibseq_slave_model slave (
    .sda_in(dline),
    .scl_in(cline),
    .rd_byte_in(rx_byte),
    .jam_in(jam),
    .sda_oe_out(slv_oe),
    .ack_seen_out(ack_seen),
    .start_cnt_out(start_cnt),
    .stop_cnt_out(stop_cnt)
  );
  // ************************************************
  // bus tasks and checking
  // ************************************************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    n_compared++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // every task but idle leaves its strobe up; the next one replaces it a full edge later
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    req <= '{a, d, 1'b1, 1'b0};
    @(posedge clock_in);
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] e, input logic [15:0] m);
    req <= '{a, 16'h0000, 1'b0, 1'b1};
    notes.push_back('{a, e & m, m});
    @(posedge clock_in);
  endtask
  task automatic idle(input int n);
    req <= '0;
    repeat (n) @(posedge clock_in);
  endtask
  // request must still stand one and a half ticks before its end and be gone just after
  task automatic go(input logic [15:0] ctl, input int ticks);
    wr(4'h0, ctl);
    rd(4'h0, ctl, 16'h001f);
    idle((ticks - 1) * QTR - 4);
    rd(4'h0, ctl, 16'h001f);
    idle(QTR + 10); // wait for the request to clear before the next one
    rd(4'h0, 16'h0000, 16'h001f);
  endtask
  task automatic txb(input logic [7:0] b, input logic [15:0] e, input logic [15:0] m);
    wr(4'h2, {8'h00, b});
    idle(2);
    rd(4'h1, 16'h4000, 16'h4000);
    wr(4'h2, 16'h00a5);
    rd(4'h1, 16'h4080, 16'h4080);
    idle(36 * QTR + 8);
    rd(4'h1, e, m);
  endtask
  always @(posedge clock_in)
  begin
    if (rd_d)
    begin
      note = notes.pop_front();
      check(reg_rdata_out & note.mask, note.exp, $sformatf("register %0d", note.addr));
    end
    rd_d <= req.read;
  end
  always @(posedge clock_in)
  begin
    cyc++;
    if (cyc == 12000)
    begin
      err_total++;
      finish_test();
    end
  end
  // ************************************************
  // main sequence
  // ************************************************
  initial
  begin
    rx_byte = 8'($random(seed));
    adr = 7'($random(seed));
    repeat (3) @(posedge clock_in);
    reset_n_in <= 1'b1;
    rd(4'h0, ibseq_pkg::CONTROL_RESET, 16'hffff);
    rd(4'h6, ibseq_pkg::DIVIDER_RESET, 16'hffff);
    rd(4'h1, 16'h0000, 16'hffff);
    rd(4'hf, 16'h0000, 16'hffff);
    wr(4'h6, 16'h0007);
    wr(4'h5, 16'h0007);
    go(16'h8001, 4);
    rd(4'h4, 16'h0001, 16'h0001);
    txb({adr, 1'b0}, 16'h0000, 16'hc000);
    wr(4'h1, 16'h0000);
    rd(4'h1, 16'h0000, 16'h0080);
    go(16'h8002, 4);
    check(16'(start_cnt), 16'h0002, "starts seen");
    txb({adr, 1'b1}, 16'h0000, 16'hc000);
    go(16'h8008, 32);
    rd(4'h3, {8'h00, rx_byte}, 16'h00ff);
    go(16'h8010, 4);
    check({15'h0000, ack_seen}, 16'h0000, "ack slot");
    go(16'h8008, 32);
    rd(4'h3, {8'h00, rx_byte}, 16'h00ff);
    go(16'h8030, 4);
    check({15'h0000, ack_seen}, 16'h0001, "ack slot");
    go(16'h8004, 4);
    check(16'(stop_cnt), 16'h0001, "stops seen");
    go(16'h8001, 4);
    jam <= 1'b1;
    txb(8'hff, 16'h0400, 16'h4400);
    rd(4'h0, 16'h0000, 16'h001f);
    rd(4'h4, 16'h0006, 16'h0006);
    jam <= 1'b0;
    idle(20);
    rd(4'h1, 16'h0400, 16'h0400);
    wr(4'h1, 16'h0000);
    rd(4'h1, 16'h0000, 16'h0480);
    wr(4'h5, 16'h0000);
    idle(3);
    check({15'h0000, irq_out}, 16'h0000, "irq_out masked");
    wr(4'h5, 16'h0007);
    idle(3);
    check({15'h0000, irq_out}, 16'h0001, "irq_out unmasked");
    wr(4'h4, 16'h0007);
    idle(3);
    check({15'h0000, irq_out}, 16'h0000, "irq_out cleared");
    rd(4'h4, 16'h0000, 16'h0007);
    idle(4);
    finish_test();
  end
endmodule
`default_nettype wire
